// *** hdl/mpss_cfg.svh ***
`ifndef MPSS_CFG_SVH
`define MPSS_CFG_SVH

// Shutdown hold on supply-good enable, in ns
`define MPSS_HOLD_NS        100000
`define MPSS_CLK_NS         8
`define MPSS_HOLD_CYC       ((`MPSS_HOLD_NS + `MPSS_CLK_NS - 1) / `MPSS_CLK_NS)
// Internal power-up time before the reset line is released, in cycles
`define MPSS_PWRUP_CYC      64
// Carrier supply ramp before outputs are enabled, in cycles
`define MPSS_RAMP_CYC       16
`define MPSS_TIMER_W        16
`define MPSS_CNT_W          24

`endif

// *** hdl/mpss_pkg.sv ***
package mpss_pkg;
  typedef enum logic [2:0] {
    MPSS_OFF,
    MPSS_PWRUP,
    MPSS_ON,
    MPSS_SLEEP,
    MPSS_SHDN_REQ,
    MPSS_PWROFF
  } mpss_state_t;

  typedef enum logic [1:0] {
    MPSS_C_OFF,
    MPSS_C_WAIT,
    MPSS_C_RAMP,
    MPSS_C_ON
  } mpss_cstate_t;
endpackage

// *** hdl/mpss_link_if.sv ***
`timescale 1ns/100ps
interface mpss_link_if;
  logic supply_good_en;
  logic shutdown_req_n;
  logic reset_dev_o;
  logic reset_dev_oe;
  logic reset_car_o;
  logic reset_car_oe;
  logic module_reset_n;

  // Open-drain wire with pull-up: any enabled low driver wins
  assign module_reset_n = !((reset_dev_oe && !reset_dev_o) ||
                            (reset_car_oe && !reset_car_o));

  modport dev
  (
    input  supply_good_en,
    output shutdown_req_n,
    output reset_dev_o,
    output reset_dev_oe,
    input  module_reset_n
  );

  modport car
  (
    output supply_good_en,
    input  shutdown_req_n,
    output reset_car_o,
    output reset_car_oe,
    input  module_reset_n
  );
endinterface

// *** hdl/mpss_device.sv ***
`timescale 1ns/100ps
`include "mpss_cfg.svh"
// How it works
// - ON entered only from PWRUP or SLEEP
// - Supply-good rising edge with power gives PWRUP
// - Carrier raises supply-good only once stable
// - Supply-good low long enough starts shutdown
// - Software shutdown accepted only in ON
// - Overtemperature shuts down from PWRUP, ON or SLEEP
// - OFF entered only from PWROFF after a shutdown event
// - SLEEP only from ON by software request
// - Outputs held at pre-sleep level in SLEEP
// - Wake returns to ON without boot
// - Leave SLEEP only on a wake event or a shutdown
// - Programmed sleep timer expiry wakes
// - Hot or cold limit crossing wakes
// - Enabled VBUS attach wakes device
// - Carrier supplies wait for reset release
// - Release reset line after internal power-up
// - Assert power-down request on shutdown event
// - Carrier drops supply-good on power-down request
// - Power-off begins only after supply-good low
// - Drive reset line low during power-off
// - Carrier inputs low while reset low
// - Reset line open-drain, both may pull
// - Sleep indicator low in SLEEP only
module mpss_device
  import mpss_pkg::*;
#(
  parameter int HOLD_CYC  = `MPSS_HOLD_CYC,
  parameter int PWRUP_CYC = `MPSS_PWRUP_CYC,
  parameter int TIMER_W   = `MPSS_TIMER_W
)
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Link to carrier
  mpss_link_if.dev                link,
  // Supply and thermal status
  input  wire logic               main_supply_ok,
  input  wire logic               temp_unsafe,
  input  wire logic               temp_hot,
  input  wire logic               temp_cold,
  // Software requests
  input  wire logic               sw_shutdown,
  input  wire logic               sw_running,
  input  wire logic               sw_sleep,
  input  wire logic [TIMER_W-1:0] sleep_timer_val,
  input  wire logic               vbus_wake_en,
  // Wake sources
  input  wire logic               vbus_present,
  input  wire logic               wake_pin,
  input  wire logic               wake_pin_en,
  // Module output data and outputs
  input  wire logic [7:0]         func_out_d,
  output      logic [7:0]         func_out,
  output      logic               sleep_indicator_n,
  output      logic               module_on,
  output      logic               reset_seen
);

  // Counters are CNT_W wide and must reach their limits
  if (HOLD_CYC < 1 || PWRUP_CYC < 1 || TIMER_W < 1 ||
      HOLD_CYC >= 2 ** `MPSS_CNT_W || PWRUP_CYC >= 2 ** `MPSS_CNT_W)
    $error("mpss_device: bad parameter");

  localparam int CW = `MPSS_CNT_W;

  mpss_state_t        state_q, state_d;
  logic               sge_q;
  logic               vbus_q;
  logic [CW-1:0]      low_cnt_q;
  logic [CW-1:0]      pu_cnt_q;
  logic [TIMER_W-1:0] tmr_q;
  logic               tmr_run_q;
  logic               rel_q;

  function automatic logic cnt_done(logic [CW-1:0] c, int lim);
    cnt_done = (c >= CW'(lim));
  endfunction

  wire sge_rise   = link.supply_good_en && !sge_q;
  wire sge_low    = !link.supply_good_en;
  wire hw_off     = cnt_done(low_cnt_q, HOLD_CYC);
  wire tmr_expire = tmr_run_q && (tmr_q == '0);
  wire vbus_rise  = vbus_present && !vbus_q;
  wire wake_evt   = tmr_expire
                  || temp_hot || temp_cold
                  || (vbus_wake_en && vbus_rise)
                  || (wake_pin_en && wake_pin);
  wire sw_off     = sw_shutdown && sw_running;
  wire in_run     = (state_q == MPSS_ON) || (state_q == MPSS_SLEEP);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      MPSS_OFF:
        if (sge_rise && main_supply_ok)
          state_d = MPSS_PWRUP;
      MPSS_PWRUP:
        if (temp_unsafe || sge_low)
          state_d = MPSS_SHDN_REQ;
        else if (cnt_done(pu_cnt_q, PWRUP_CYC))
          state_d = MPSS_ON;
      MPSS_ON:
        if (temp_unsafe || sw_off || hw_off)
          state_d = MPSS_SHDN_REQ;
        else if (sw_sleep)
          state_d = MPSS_SLEEP;
      MPSS_SLEEP:
        if (temp_unsafe || hw_off)
          state_d = MPSS_SHDN_REQ;
        else if (wake_evt)
          state_d = MPSS_ON;
      MPSS_SHDN_REQ:
        if (sge_low)
          state_d = MPSS_PWROFF;
      MPSS_PWROFF:
        state_d = MPSS_OFF;
      default:
        state_d = MPSS_OFF;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= MPSS_OFF;
      sge_q   <= 1'b0;
      vbus_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      sge_q   <= link.supply_good_en;
      vbus_q  <= vbus_present;
    end
  end

  // Low-time counter saturates so a long hold never wraps
  always_ff @(posedge core_clk)
  begin
    if (rst || !sge_low || !in_run)
      low_cnt_q <= '0;
    else if (!hw_off)
      low_cnt_q <= low_cnt_q + CW'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || state_q != MPSS_PWRUP)
      pu_cnt_q <= '0;
    else
      pu_cnt_q <= pu_cnt_q + CW'(1);
  end

  // Timer loaded on sleep entry; zero load means no timer wake
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tmr_q     <= '0;
      tmr_run_q <= 1'b0;
    end
    else if (state_q == MPSS_ON && state_d == MPSS_SLEEP)
    begin
      tmr_q     <= sleep_timer_val;
      tmr_run_q <= (sleep_timer_val != '0);
    end
    else if (state_q != MPSS_SLEEP)
      tmr_run_q <= 1'b0;
    else if (tmr_q != '0)
      tmr_q <= tmr_q - TIMER_W'(1);
  end

  // Line stays released through the shutdown request until supply-good
  // is seen low; an aborted power-up never releases it
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rel_q <= 1'b0;
    else if (state_d == MPSS_ON)
      rel_q <= 1'b1;
    else if (state_d == MPSS_PWROFF || state_d == MPSS_OFF)
      rel_q <= 1'b0;
  end

  // Outputs frozen in SLEEP, zero while not running
  always_ff @(posedge core_clk)
  begin
    if (rst)
      func_out <= 8'h00;
    else if (state_q == MPSS_ON && state_d != MPSS_SLEEP)
      func_out <= func_out_d;
    else if (!in_run)
      func_out <= 8'h00;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sleep_indicator_n <= 1'b1;
      module_on         <= 1'b0;
      reset_seen        <= 1'b0;
    end
    else
    begin
      sleep_indicator_n <= (state_d != MPSS_SLEEP);
      module_on         <= (state_d == MPSS_ON);
      reset_seen        <= !link.module_reset_n && in_run;
    end
  end

  assign link.shutdown_req_n = (state_q != MPSS_SHDN_REQ);
  // Reset line held low until ON and again from PWROFF; released is undriven
  assign link.reset_dev_o    = 1'b0;
  assign link.reset_dev_oe   = !rel_q;

endmodule

// *** hdl/mpss_carrier.sv ***
`timescale 1ns/100ps
`include "mpss_cfg.svh"
module mpss_carrier
  import mpss_pkg::*;
#(
  parameter int RAMP_CYC = `MPSS_RAMP_CYC
)
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Link to device
  mpss_link_if.car        link,
  // Board side
  input  wire logic       vdd_in_stable,
  input  wire logic       power_off_cmd,
  input  wire logic       force_reset,
  input  wire logic [7:0] io_drive_d,
  output      logic [7:0] io_drive,
  output      logic       carrier_supply_en
);

  // Ramp counter is 16 bits and saturates
  if (RAMP_CYC < 1 || RAMP_CYC > 16'hFFFF)
    $error("mpss_carrier: bad parameter");

  mpss_cstate_t state_q, state_d;
  logic [15:0]  ramp_q;

  wire rst_rel = link.module_reset_n;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      MPSS_C_OFF:
        if (vdd_in_stable && !power_off_cmd)
          state_d = MPSS_C_WAIT;
      MPSS_C_WAIT:
        if (!vdd_in_stable || !link.shutdown_req_n)
          state_d = MPSS_C_OFF;
        else if (rst_rel)
          state_d = MPSS_C_RAMP;
      MPSS_C_RAMP:
        if (!vdd_in_stable || !link.shutdown_req_n || !rst_rel)
          state_d = MPSS_C_OFF;
        else if (ramp_q >= 16'(RAMP_CYC))
          state_d = MPSS_C_ON;
      MPSS_C_ON:
        if (!vdd_in_stable || !link.shutdown_req_n || !rst_rel)
          state_d = MPSS_C_OFF;
      default:
        state_d = MPSS_C_OFF;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_q <= MPSS_C_OFF;
    else
      state_q <= state_d;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || state_q != MPSS_C_RAMP)
      ramp_q <= 16'h0000;
    else if (ramp_q != 16'hFFFF)
      ramp_q <= ramp_q + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || !rst_rel || state_d != MPSS_C_ON)
      io_drive <= 8'h00;
    else
      io_drive <= io_drive_d;
  end

  // Supply-good drops straight away on a power-down request
  assign link.supply_good_en = (state_q != MPSS_C_OFF) &&
                               link.shutdown_req_n;
  assign carrier_supply_en   = (state_q == MPSS_C_RAMP) ||
                               (state_q == MPSS_C_ON);
  assign link.reset_car_o    = 1'b0;
  assign link.reset_car_oe   = force_reset;

endmodule

// *** dv/mpss_chk.sv ***
`timescale 1ns/100ps
module mpss_chk
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link wires
  input wire logic supply_good_en,
  input wire logic shutdown_req_n,
  input wire logic reset_dev_o,
  input wire logic reset_dev_oe,
  input wire logic reset_car_o,
  input wire logic reset_car_oe,
  input wire logic module_reset_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_reset_idle:
    assert property ($fell(rst) |-> reset_dev_oe && shutdown_req_n)
    else $error("link not idle after reset");
  chk_pwrup_hold:
    assert property ($rose(supply_good_en) && reset_dev_oe
                     |=> reset_dev_oe [*4])
    else $error("reset line released too early");
  chk_release_sge:
    assert property ($fell(reset_dev_oe) |-> supply_good_en)
    else $error("reset released without supply good");
  chk_pwroff_sge:
    assert property ($rose(reset_dev_oe) |-> !supply_good_en)
    else $error("power-off before supply good low");
  chk_rst_after_sge:
    assert property (!reset_dev_oe && supply_good_en |=> !reset_dev_oe)
    else $error("reset line pulled while supply good high");
  chk_req_served:
    assert property (!shutdown_req_n |-> !supply_good_en)
    else $error("power-down request not served");
  chk_req_to_off:
    assert property ($fell(shutdown_req_n) |-> ##[1:4] reset_dev_oe)
    else $error("reset line not pulled after request");
  chk_dev_od:
    assert property (reset_dev_oe |-> !reset_dev_o)
    else $error("device drives reset line high");
  chk_car_od:
    assert property (reset_car_oe |-> !reset_car_o)
    else $error("carrier drives reset line high");
endmodule

// *** dv/module_power_state_sequencer_test.sv ***
`timescale 1ns/100ps
module module_power_state_sequencer_test;
  logic core_clk = 0, rst = 1;
  logic mso, tun, thot, tcold, sws, swr, swl, vben, vbus, wp, wpen;
  logic vdd, poff, frst;
  logic [15:0] tval;
  logic [7:0] fod, fo, iod, io;
  logic sin, mon, rseen, cse;
  int bad_count = 0, n_checks = 0;

  mpss_link_if link ();
  mpss_device #(.HOLD_CYC(4), .PWRUP_CYC(4), .TIMER_W(16)) i_mpss_device (
    .core_clk(core_clk), .rst(rst), .link(link), .main_supply_ok(mso),
    .temp_unsafe(tun), .temp_hot(thot), .temp_cold(tcold),
    .sw_shutdown(sws), .sw_running(swr), .sw_sleep(swl),
    .sleep_timer_val(tval), .vbus_wake_en(vben), .vbus_present(vbus),
    .wake_pin(wp), .wake_pin_en(wpen), .func_out_d(fod), .func_out(fo),
    .sleep_indicator_n(sin), .module_on(mon), .reset_seen(rseen));
  mpss_carrier #(.RAMP_CYC(2)) i_mpss_carrier (
    .core_clk(core_clk), .rst(rst), .link(link), .vdd_in_stable(vdd),
    .power_off_cmd(poff), .force_reset(frst), .io_drive_d(iod),
    .io_drive(io), .carrier_supply_en(cse));
  mpss_chk i_mpss_chk (
    .core_clk(core_clk), .rst(rst),
    .supply_good_en(link.supply_good_en),
    .shutdown_req_n(link.shutdown_req_n), .reset_dev_o(link.reset_dev_o),
    .reset_dev_oe(link.reset_dev_oe), .reset_car_o(link.reset_car_o),
    .reset_car_oe(link.reset_car_oe), .module_reset_n(link.module_reset_n));

  always #4 core_clk = ~core_clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic chk(input logic c, input string m);
    n_checks++;
    if (c !== 1'b1)
    begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // Bounded wait for the module to reach or leave ON
  task automatic wait_on(input logic v);
    for (int i = 0; i < 40 && mon !== v; i++) cyc(1);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic no_supply;
    cyc(20);
    chk(mon === 1'b0, "woke without main supply");
    chk(io === 8'h00, "carrier io high under reset");
  endtask

  // Supply-good low long enough to shut down, then a fresh rise
  task automatic power_up;
    vdd = 0;
    poff = 1;
    cyc(10);
    mso = 1;
    vdd = 1;
    cyc(4);
    chk(link.supply_good_en === 1'b0, "supply good while blocked");
    poff = 0;
    wait_on(1);
    chk(mon === 1'b1, "no power-up");
    chk(link.module_reset_n === 1'b1, "reset not released");
    cyc(6);
    chk(cse === 1'b1, "carrier supply not enabled");
  endtask

  // Supply loss drops supply-good; power_up restores the supply
  task automatic glitch_then_off;
    vdd = 0;
    cyc(2);
    vdd = 1;
    cyc(10);
    chk(mon === 1'b1, "short low pulse shut down");
    vdd = 0;
    wait_on(0);
    cyc(2);
    chk(link.module_reset_n === 1'b0, "no hardware shutdown");
  endtask

  // Carrier pulls the shared reset line while the module runs
  task automatic carrier_reset;
    frst = 1;
    cyc(2);
    chk(rseen === 1'b1, "carrier reset not seen");
    chk(cse === 1'b0 && io === 8'h00, "carrier on under reset");
    frst = 0;
    cyc(8);
    chk(rseen === 1'b0 && mon === 1'b1, "module lost run");
    chk(cse === 1'b1 && io === 8'hFF, "carrier not back on");
  endtask

  // Sources: 0 timer, 1 hot, 2 cold, 3 vbus, 4 wake pin
  task automatic sleep_wake(input int src);
    fod = 8'hA5;
    tval = (src == 0) ? 16'h000A : 16'h0000;
    cyc(2);
    swl = 1;
    cyc(1);
    swl = 0;
    fod = 8'h3C;
    cyc(5);
    chk(sin === 1'b0 && mon === 1'b0, "not asleep");
    chk(fo === 8'hA5, "outputs not held in sleep");
    chk(sin === 1'b0, "left sleep without wake");
    case (src)
      1: thot = 1;
      2: tcold = 1;
      3: vbus = 1;
      4: wp = 1;
      default: ;
    endcase
    wait_on(1);
    chk(mon === 1'b1 && sin === 1'b1, "no wake");
    chk(link.module_reset_n === 1'b1, "wake ran a boot");
    {thot, tcold, vbus, wp} = '0;
  endtask

  // Sleep ignores software shutdown and disabled wake sources
  task automatic sleep_faults;
    swl = 1;
    cyc(1);
    swl = 0;
    sws = 1;
    {vben, wpen} = '0;
    {vbus, wp} = '1;
    cyc(8);
    chk(sin === 1'b0, "software shutdown taken in sleep");
    chk(mon === 1'b0, "disabled wake source woke");
    {sws, vbus, wp} = '0;
    {vben, wpen} = '1;
    tun = 1;
    cyc(10);
    chk(link.module_reset_n === 1'b0, "no thermal shutdown");
    tun = 0;
  endtask

  task automatic sw_off;
    swr = 0;
    sws = 1;
    cyc(3);
    chk(mon === 1'b1, "shutdown without software");
    swr = 1;
    cyc(1);
    chk(link.shutdown_req_n === 1'b0, "no power-down request");
    chk(link.module_reset_n === 1'b1, "reset too early");
    sws = 0;
    wait_on(0);
    cyc(2);
    chk(link.module_reset_n === 1'b0, "not off");
  endtask

  initial
  begin
    {mso, tun, thot, tcold, sws, swl, vbus, wp, poff, frst} = '0;
    {swr, vben, wpen, vdd} = '1;
    tval = 16'h0000;
    fod = 8'h00;
    iod = 8'hFF;
    cyc(3);
    rst = 0;
    no_supply();
    power_up();
    glitch_then_off();
    power_up();
    carrier_reset();
    for (int s = 0; s < 5; s++) sleep_wake(s);
    sleep_faults();
    power_up();
    sw_off();
    finish_test();
  end

  initial
  begin
    #40000;
    bad_count++;
    finish_test();
  end
endmodule
